// ### ssq_pkg.sv
// shared constants and types of the setpoint step-program sequencer
package ssq_pkg;

	// ----------------------------------------
	// sizes
	// ----------------------------------------
	localparam int STEPS_MAX = 8;
	localparam int STEPS_DEFAULT = 1;
	localparam int CONTACTS = 5;
	localparam int VAL_W = 16;

	// ----------------------------------------
	// contact operation types
	// ----------------------------------------
	localparam logic [4:0] CONTACT_NONE = 5'h00;
	localparam logic [4:0] CONTACT_RAMP_CTL = 5'h0d;

	// ----------------------------------------
	// ramp type, units, start and end settings
	// ----------------------------------------
	localparam logic [1:0] RT_STANDARD = 2'h0;
	localparam logic [1:0] RT_MULTI = 2'h1;
	localparam logic [1:0] RT_STEP_NORESUME = 2'h2;
	localparam logic [1:0] RT_STEP_RESUME = 2'h3;
	localparam logic [1:0] RAMP_TYPE_RESET = RT_STANDARD;
	localparam logic [1:0] SLOPE_PER_SEC = 2'h0;
	localparam logic [1:0] SLOPE_PER_MIN = 2'h1;
	localparam logic [1:0] SLOPE_PER_HOUR = 2'h2;
	localparam logic [1:0] SLOPE_UNIT_RESET = SLOPE_PER_MIN;
	localparam logic [1:0] SOAK_TENTH = 2'h0;
	localparam logic [1:0] SOAK_SEC = 2'h1;
	localparam logic [1:0] SOAK_MIN = 2'h2;
	localparam logic [1:0] SOAK_UNIT_RESET = SOAK_TENTH;
	localparam logic [1:0] PVS_NONE = 2'h0;
	localparam logic [1:0] PVS_UP = 2'h1;
	localparam logic [1:0] PVS_DOWN = 2'h2;
	localparam logic [1:0] LOOP_STOP = 2'h0;
	localparam logic [1:0] LOOP_REPEAT = 2'h1;
	localparam logic [1:0] LOOP_HOLD = 2'h2;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int TENTH_NS = 100_000_000;
	localparam int TENTH_CYCLES = TENTH_NS / CLK_PERIOD_NS;
	localparam int TENTHS_PER_SEC = 10;
	localparam int SEC_PER_MIN = 60;
	localparam int MIN_PER_HOUR = 60;

	// ----------------------------------------
	// remaining-time display
	// ----------------------------------------
	localparam logic [15:0] REM_SAT_TENTH = 16'h270f;
	localparam logic [15:0] REM_SAT_SEXA = 16'h176f;
	localparam logic [15:0] DISP_RADIX = 16'h0064;
	localparam logic [15:0] SEXA_RADIX = 16'h003c;
	localparam logic [6:0] DISP_SAT = 7'h63;

	typedef enum logic [2:0] {
		SSQ_IDLE,
		SSQ_RAMP_ENTRY,
		SSQ_RAMP,
		SSQ_SOAK_ENTRY,
		SSQ_SOAK,
		SSQ_HOLD
	} ssq_state_t;

endpackage : ssq_pkg

// ### ssq_timebase.sv
// time base: tenth, second, minute and hour tick pulses
`timescale 1ns/100ps

module ssq_timebase #(
	parameter int TENTH_CYCLES = ssq_pkg::TENTH_CYCLES
) (
	input wire logic clk_sys,
	input wire logic srst,
	output logic tickTenth,
	output logic tickSec,
	output logic tickMin,
	output logic tickHour
);

	localparam int CW = $clog2(TENTH_CYCLES);

	if (TENTH_CYCLES < 2) begin : g_chk
		$error("ssq_timebase: TENTH_CYCLES must be at least 2");
	end

	logic [CW-1:0] cyc_q;
	logic [3:0] tenth_q;
	logic [5:0] sec_q;
	logic [5:0] min_q;
	logic wrapTenth, wrapSec, wrapMin, wrapHour;

	assign wrapTenth = cyc_q == CW'(TENTH_CYCLES - 1);
	assign wrapSec = wrapTenth && tenth_q == 4'(ssq_pkg::TENTHS_PER_SEC - 1);
	assign wrapMin = wrapSec && sec_q == 6'(ssq_pkg::SEC_PER_MIN - 1);
	assign wrapHour = wrapMin && min_q == 6'(ssq_pkg::MIN_PER_HOUR - 1);

	// ----------------------------------------
	// cascaded counters
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cyc_q <= '0;
			tenth_q <= '0;
			sec_q <= '0;
			min_q <= '0;
		end else begin
			cyc_q <= wrapTenth ? '0 : cyc_q + 1'b1;
			if (wrapTenth) tenth_q <= wrapSec ? '0 : tenth_q + 1'b1;
			if (wrapSec) sec_q <= wrapMin ? '0 : sec_q + 1'b1;
			if (wrapMin) min_q <= wrapHour ? '0 : min_q + 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			tickTenth <= 1'b0;
			tickSec <= 1'b0;
			tickMin <= 1'b0;
			tickHour <= 1'b0;
		end else begin
			tickTenth <= wrapTenth;
			tickSec <= wrapSec;
			tickMin <= wrapMin;
			tickHour <= wrapHour;
		end
	end

endmodule : ssq_timebase

// ### ssq_sequencer.sv
// setpoint step-program sequencer: ramp/soak steps, resume policy, checkpoints
`timescale 1ns/100ps

module ssq_sequencer #(
	parameter int STEPS = ssq_pkg::STEPS_MAX,
	parameter int CONTACTS = ssq_pkg::CONTACTS,
	parameter int TENTH_CYCLES = ssq_pkg::TENTH_CYCLES
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic runMode,
	input wire logic autoMode,
	input wire logic powerUp,
	input wire logic [4:0] contactType [CONTACTS],
	input wire logic [CONTACTS-1:0] digitalInputContact,
	input wire logic [1:0] rampType,
	input wire logic [1:0] rampSlopeUnitSetting,
	input wire logic [1:0] soakUnit,
	input wire logic [1:0] pvStartMode,
	input wire logic [1:0] loopMode,
	input wire logic [3:0] stepCount,
	input wire logic signed [15:0] localSetpoint [STEPS],
	input wire logic [15:0] stepRampRate [STEPS],
	input wire logic [15:0] stepSoakTime [STEPS],
	input wire logic signed [15:0] processValue,
	input wire logic processValueAlarm,
	input wire logic [7:0] rangeType,
	input wire logic rangeLinear,
	input wire logic signed [15:0] rangeLow,
	input wire logic signed [15:0] rangeHigh,
	input wire logic limitWrite,
	input wire logic signed [15:0] limitLowIn,
	input wire logic signed [15:0] limitHighIn,
	input wire logic nvRunning,
	input wire logic [$clog2(STEPS)-1:0] nvStep,
	input wire logic nvInSoak,
	input wire logic signed [15:0] nvStartSp,
	output logic signed [15:0] setpoint,
	output logic [$clog2(STEPS)-1:0] stepIndex,
	output logic inRamp,
	output logic inSoak,
	output logic rampDisabled,
	output logic forceReady,
	output logic nvWrite,
	output logic nvWriteRunning,
	output logic [$clog2(STEPS)-1:0] nvWriteStep,
	output logic nvWriteSoak,
	output logic signed [15:0] nvWriteStartSp,
	output logic [6:0] remainHi,
	output logic [6:0] remainLo,
	output logic signed [15:0] spLowLimit,
	output logic signed [15:0] spHighLimit
);

	localparam int IW = $clog2(STEPS);

	if (STEPS < 2 || STEPS > ssq_pkg::STEPS_MAX || CONTACTS < 1) begin : g_chk
		$error("ssq_sequencer: STEPS must be 2..8 and CONTACTS at least 1");
	end

	ssq_pkg::ssq_state_t state_q;
	logic [IW-1:0] step_q;
	logic signed [15:0] sp_q;
	logic signed [15:0] startSp_q;
	logic [15:0] soak_q;
	logic runAutoPrev_q;
	logic [1:0] rampTypePrev_q;
	logic [7:0] rangePrev_q;

	logic tickTenth, tickSec, tickMin, tickHour;
	logic slopeTick, soakTick;
	logic [CONTACTS-1:0] ctlHit;
	logic stepEnabled, resumeType, runAuto, runStart, autoRise;
	logic [IW-1:0] lastIdx;
	logic lastStep, advanceNow, typeEnter;
	logic signed [15:0] target;
	logic signed [16:0] upSum, downSum;

	// ----------------------------------------
	// time base
	// ----------------------------------------
	ssq_timebase #(
		.TENTH_CYCLES(TENTH_CYCLES)
	) u_timebase (
		.clk_sys(clk_sys),
		.srst(srst),
		.tickTenth(tickTenth),
		.tickSec(tickSec),
		.tickMin(tickMin),
		.tickHour(tickHour)
	);

	always_comb begin
		case (rampSlopeUnitSetting)
			ssq_pkg::SLOPE_PER_SEC: slopeTick = tickSec;
			ssq_pkg::SLOPE_PER_MIN: slopeTick = tickMin;
			ssq_pkg::SLOPE_PER_HOUR: slopeTick = tickHour;
			default: slopeTick = 1'b0;
		endcase
		case (soakUnit)
			ssq_pkg::SOAK_TENTH: soakTick = tickTenth;
			ssq_pkg::SOAK_SEC: soakTick = tickSec;
			ssq_pkg::SOAK_MIN: soakTick = tickMin;
			default: soakTick = 1'b0;
		endcase
	end

	// ----------------------------------------
	// ramp-control contacts
	// ----------------------------------------
	for (genvar i = 0; i < CONTACTS; i++) begin : g_contact
		// on = disabled; other operation types are ignored here
		assign ctlHit[i] = contactType[i] == ssq_pkg::CONTACT_RAMP_CTL && digitalInputContact[i];
	end
	assign rampDisabled = |ctlHit;

	// ----------------------------------------
	// sequencing decisions
	// ----------------------------------------
	// out-of-range count falls back to the default single step
	assign lastIdx = (stepCount == 4'h0 || 32'(stepCount) > STEPS) ? IW'(ssq_pkg::STEPS_DEFAULT - 1)
		: IW'(stepCount - 4'h1);
	assign lastStep = step_q == lastIdx;
	assign stepEnabled = rampType == ssq_pkg::RT_STEP_NORESUME || rampType == ssq_pkg::RT_STEP_RESUME;
	assign resumeType = rampType == ssq_pkg::RT_STEP_RESUME;
	assign runAuto = runMode && autoMode;
	assign runStart = runAuto && !runAutoPrev_q && stepEnabled && state_q == ssq_pkg::SSQ_IDLE;
	assign autoRise = runAuto && !runAutoPrev_q;
	assign typeEnter = runMode && !rampTypePrev_q[1] && rampType[1];
	assign target = localSetpoint[step_q];
	assign upSum = 17'(sp_q) + 17'(stepRampRate[step_q]);
	assign downSum = 17'(sp_q) - 17'(stepRampRate[step_q]);
	assign advanceNow = (state_q == ssq_pkg::SSQ_SOAK_ENTRY && stepSoakTime[step_q] == 16'h0000)
		|| (state_q == ssq_pkg::SSQ_SOAK && soakTick && soak_q <= 16'h0001);

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			runAutoPrev_q <= 1'b0;
			rampTypePrev_q <= ssq_pkg::RAMP_TYPE_RESET;
		end else begin
			runAutoPrev_q <= runAuto;
			rampTypePrev_q <= rampType;
		end
	end

	// ----------------------------------------
	// program state machine
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_q <= ssq_pkg::SSQ_IDLE;
			step_q <= '0;
			sp_q <= '0;
			startSp_q <= '0;
			soak_q <= '0;
			forceReady <= 1'b0;
			nvWrite <= 1'b0;
			nvWriteRunning <= 1'b0;
			nvWriteStep <= '0;
			nvWriteSoak <= 1'b0;
			nvWriteStartSp <= '0;
		end else begin
			forceReady <= typeEnter;
			nvWrite <= 1'b0;
			if (powerUp && nvRunning && rampType == ssq_pkg::RT_STEP_NORESUME) begin
				forceReady <= 1'b1;
				sp_q <= nvStartSp;
				state_q <= ssq_pkg::SSQ_IDLE;
				step_q <= '0;
			end else if (powerUp && nvRunning && resumeType) begin
				step_q <= nvStep;
				startSp_q <= nvStartSp;
				if (nvInSoak || processValueAlarm) begin
					sp_q <= localSetpoint[nvStep];
					state_q <= ssq_pkg::SSQ_SOAK_ENTRY;
				end else begin
					sp_q <= processValue;
					state_q <= ssq_pkg::SSQ_RAMP_ENTRY;
				end
			end else if (!runMode || !stepEnabled || typeEnter) begin
				if (state_q != ssq_pkg::SSQ_IDLE) begin
					// clear the run flag so a later power-up does not resume
					nvWrite <= 1'b1;
					nvWriteRunning <= 1'b0;
				end
				state_q <= ssq_pkg::SSQ_IDLE;
				step_q <= '0;
			end else if (advanceNow) begin
				if (!lastStep) begin
					step_q <= step_q + 1'b1;
					state_q <= ssq_pkg::SSQ_RAMP_ENTRY;
				end else begin
					case (loopMode)
						ssq_pkg::LOOP_REPEAT: begin
							step_q <= '0;
							state_q <= ssq_pkg::SSQ_RAMP_ENTRY;
						end
						ssq_pkg::LOOP_HOLD: state_q <= ssq_pkg::SSQ_HOLD;
						default: begin
							forceReady <= 1'b1;
							state_q <= ssq_pkg::SSQ_IDLE;
							step_q <= '0;
						end
					endcase
				end
			end else begin
				case (state_q)
					ssq_pkg::SSQ_IDLE: begin
						if (runStart) begin
							step_q <= '0;
							nvWrite <= !resumeType;
							nvWriteRunning <= 1'b1;
							nvWriteStep <= '0;
							nvWriteSoak <= 1'b0;
							if (pvStartMode == ssq_pkg::PVS_UP && processValue < localSetpoint[0]) begin
								sp_q <= processValue;
								startSp_q <= processValue;
								nvWriteStartSp <= processValue;
								state_q <= ssq_pkg::SSQ_RAMP_ENTRY;
							end else if (pvStartMode == ssq_pkg::PVS_DOWN && processValue > localSetpoint[0]) begin
								sp_q <= processValue;
								startSp_q <= processValue;
								nvWriteStartSp <= processValue;
								state_q <= ssq_pkg::SSQ_RAMP_ENTRY;
							end else begin
								sp_q <= localSetpoint[0];
								startSp_q <= localSetpoint[0];
								nvWriteStartSp <= localSetpoint[0];
								state_q <= ssq_pkg::SSQ_SOAK_ENTRY;
							end
						end
					end
					ssq_pkg::SSQ_RAMP_ENTRY: begin
						if (stepRampRate[step_q] == 16'h0000 || sp_q == target || rampDisabled) begin
							state_q <= ssq_pkg::SSQ_SOAK_ENTRY;
						end else begin
							state_q <= ssq_pkg::SSQ_RAMP;
							nvWrite <= resumeType;
							nvWriteRunning <= 1'b1;
							nvWriteStep <= step_q;
							nvWriteSoak <= 1'b0;
							nvWriteStartSp <= startSp_q;
						end
					end
					ssq_pkg::SSQ_RAMP: begin
						if (rampDisabled) begin
							state_q <= ssq_pkg::SSQ_SOAK_ENTRY;
						end else if (autoRise) begin
							sp_q <= processValue;
						end else if (slopeTick) begin
							if (sp_q < target) begin
								sp_q <= upSum >= 17'(target) ? target : upSum[15:0];
								if (upSum >= 17'(target)) state_q <= ssq_pkg::SSQ_SOAK_ENTRY;
							end else begin
								sp_q <= downSum <= 17'(target) ? target : downSum[15:0];
								if (downSum <= 17'(target)) state_q <= ssq_pkg::SSQ_SOAK_ENTRY;
							end
						end
					end
					ssq_pkg::SSQ_SOAK_ENTRY: begin
						soak_q <= stepSoakTime[step_q];
						state_q <= ssq_pkg::SSQ_SOAK;
						nvWrite <= resumeType;
						nvWriteRunning <= 1'b1;
						nvWriteStep <= step_q;
						nvWriteSoak <= 1'b1;
						nvWriteStartSp <= startSp_q;
					end
					ssq_pkg::SSQ_SOAK: begin
						if (soakTick) soak_q <= soak_q - 1'b1;
					end
					ssq_pkg::SSQ_HOLD: state_q <= ssq_pkg::SSQ_HOLD;
					default: state_q <= ssq_pkg::SSQ_IDLE;
				endcase
			end
		end
	end

	assign setpoint = sp_q;
	assign stepIndex = step_q;
	assign inRamp = state_q == ssq_pkg::SSQ_RAMP;
	assign inSoak = state_q == ssq_pkg::SSQ_SOAK || state_q == ssq_pkg::SSQ_HOLD;

	// ----------------------------------------
	// remaining-time display
	// ----------------------------------------
	logic [15:0] remVal;
	assign remVal = state_q == ssq_pkg::SSQ_SOAK ? soak_q : stepSoakTime[step_q];

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			remainHi <= '0;
			remainLo <= '0;
		end else if (soakUnit == ssq_pkg::SOAK_TENTH) begin
			remainHi <= remVal > ssq_pkg::REM_SAT_TENTH ? ssq_pkg::DISP_SAT : 7'(remVal / ssq_pkg::DISP_RADIX);
			remainLo <= remVal > ssq_pkg::REM_SAT_TENTH ? ssq_pkg::DISP_SAT : 7'(remVal % ssq_pkg::DISP_RADIX);
		end else begin
			// MM.SS or HH.MM: same base-60 split; saturates at 99.99
			remainHi <= remVal > ssq_pkg::REM_SAT_SEXA ? ssq_pkg::DISP_SAT : 7'(remVal / ssq_pkg::SEXA_RADIX);
			remainLo <= remVal > ssq_pkg::REM_SAT_SEXA ? ssq_pkg::DISP_SAT : 7'(remVal % ssq_pkg::SEXA_RADIX);
		end
	end

	// ----------------------------------------
	// setpoint limits
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rangePrev_q <= rangeType;
			spLowLimit <= rangeLow;
			spHighLimit <= rangeHigh;
		end else begin
			rangePrev_q <= rangeType;
			if (rangeType != rangePrev_q && !rangeLinear) begin
				spLowLimit <= rangeLow;
				spHighLimit <= rangeHigh;
			end else if (limitWrite) begin
				spLowLimit <= limitLowIn;
				spHighLimit <= limitHighIn;
			end
		end
	end

endmodule : ssq_sequencer

// ### ssq_sequencer_monitor.sv
// concurrent checks on the sequencer ports
`timescale 1ns/100ps

module ssq_sequencer_monitor #(
	parameter int STEPS = 8,
	parameter int CONTACTS = 5
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic runMode,
	input wire logic autoMode,
	input wire logic powerUp,
	input wire logic [4:0] contactType [CONTACTS],
	input wire logic [CONTACTS-1:0] digitalInputContact,
	input wire logic [1:0] rampType,
	input wire logic [1:0] soakUnit,
	input wire logic [1:0] pvStartMode,
	input wire logic signed [15:0] localSetpoint [STEPS],
	input wire logic signed [15:0] processValue,
	input wire logic [7:0] rangeType,
	input wire logic rangeLinear,
	input wire logic signed [15:0] rangeLow,
	input wire logic signed [15:0] rangeHigh,
	input wire logic signed [15:0] setpoint,
	input wire logic [$clog2(STEPS)-1:0] stepIndex,
	input wire logic inRamp,
	input wire logic inSoak,
	input wire logic rampDisabled,
	input wire logic forceReady,
	input wire logic nvWrite,
	input wire logic nvWriteSoak,
	input wire logic [6:0] remainHi,
	input wire logic [6:0] remainLo,
	input wire logic signed [15:0] spLowLimit,
	input wire logic signed [15:0] spHighLimit
);
	logic anyCtl;
	logic runAuto;
	logic signed [15:0] expStart;

	always_comb begin
		anyCtl = 1'b0;
		for (int i = 0; i < CONTACTS; i++) begin
			anyCtl = anyCtl | (digitalInputContact[i] & (contactType[i] == 5'h0d));
		end
	end
	assign runAuto = runMode & autoMode;
	// pv start ramps only when pv sits on the far side of step 1
	assign expStart = ((pvStartMode == 2'h1 && processValue < localSetpoint[0])
		|| (pvStartMode == 2'h2 && processValue > localSetpoint[0])) ? processValue : localSetpoint[0];

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	property p_ramp_ctl;
		rampDisabled == anyCtl;
	endproperty
	a_ramp_ctl: assert property (p_ramp_ctl) else $error("ramp disable off contacts");

	property p_ready_home;
		!runMode && !powerUp |-> ##[1:2] (stepIndex == '0 && !inRamp && !inSoak);
	endproperty
	a_ready_home: assert property (p_ready_home) else $error("ready did not go home");

	property p_force_ready;
		runMode && rampType[1] && !$past(rampType[1]) |-> ##[0:2] forceReady;
	endproperty
	a_force_ready: assert property (p_force_ready) else $error("no forced ready");

	property p_range;
		rangeType != $past(rangeType) && !rangeLinear |=> spLowLimit == $past(rangeLow) && spHighLimit == $past(rangeHigh);
	endproperty
	a_range: assert property (p_range) else $error("limits not reset");

	property p_freeze;
		runMode && !powerUp && inRamp && rampDisabled |=> !inRamp && setpoint == $past(setpoint);
	endproperty
	a_freeze: assert property (p_freeze) else $error("ramp not frozen");

	property p_checkpoint;
		runMode && rampType == 2'h3 && $past(rampType) == 2'h3 && ($rose(inRamp) || $rose(inSoak))
			|-> nvWrite && nvWriteSoak == inSoak;
	endproperty
	a_checkpoint: assert property (p_checkpoint) else $error("segment start not saved");

	property p_start;
		runAuto && !$past(runMode) && rampType[1] && !powerUp |-> ##[1:2] (setpoint == expStart && stepIndex == '0);
	endproperty
	a_start: assert property (p_start) else $error("wrong start setpoint");

	property p_rem;
		soakUnit != 2'h0 && $past(soakUnit) == soakUnit |-> remainLo <= 7'h3b || (remainHi == 7'h63 && remainLo == 7'h63);
	endproperty
	a_rem: assert property (p_rem) else $error("bad sexagesimal digits");
endmodule : ssq_sequencer_monitor

bind ssq_sequencer ssq_sequencer_monitor #(.STEPS(STEPS), .CONTACTS(CONTACTS)) i_mon (.*);

// ### ssq_core_model.sv
// controller core model: owner of run/ready mode
`timescale 1ns/100ps

module ssq_core_model (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic runCmd,
	input wire logic forceReady,
	output logic runMode
);
	logic runMode_q;
	logic armed_q;

	// forced ready sticks until run is dropped, so no silent restart
	always_ff @(posedge clk_sys) begin
		if (srst || !runCmd) begin
			runMode_q <= 1'b0;
			armed_q <= 1'b1;
		end else if (forceReady) begin
			runMode_q <= 1'b0;
			armed_q <= 1'b0;
		end else begin
			runMode_q <= armed_q;
		end
	end
	assign runMode = runMode_q;
endmodule : ssq_core_model

// ### setpoint_step_program_sequencer_bench.sv
// self-checking bench of the step-program sequencer
`timescale 1ns/100ps

module setpoint_step_program_sequencer_bench;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic runCmd, runMode, powerUp, pvAlarm, rangeLinear, limitWrite, nvRunning, nvInSoak, e, autoM;
	logic inRamp, inSoak, rampDisabled, forceReady, nvWrite, nvWRun;
	logic [4:0] cType [5];
	logic [4:0] dic;
	logic [1:0] rampType, soakUnit, pvStart, loopMode;
	logic [3:0] stepCount;
	logic signed [15:0] local_setpoint [8];
	logic [15:0] rate [8];
	logic [15:0] soakT [8];
	logic signed [15:0] pv, rangeLow, rangeHigh, limLo, limHi, nvStartSp, setpoint, spLo, spHi, sp;
	logic [7:0] rangeType;
	logic [2:0] nvStep, stepIndex;
	logic [6:0] remHi, remLo;
	logic [31:0] r;
	logic [1:0] remU [5] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2};
	logic [15:0] remT [5] = '{16'h04d2, 16'h2710, 16'h007d, 16'h1770, 16'h003d};
	logic [1:0] pvsT [5] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h2};
	logic signed [15:0] pvT [5] = '{16'h0078, 16'h005a, 16'h0078, 16'h0078, 16'h005a};
	int error_cnt = 0;
	int checked = 0;
	int seed = 43;
	int nvCnt, t0;

	always #5 clk_sys = ~clk_sys;
	// pulse is launched on the rising edge, so count it where it has settled
	always @(negedge clk_sys) if (nvWrite === 1'b1 && nvWRun === 1'b1) nvCnt++;

	ssq_core_model i_core (.clk_sys(clk_sys), .srst(srst), .runCmd(runCmd), .forceReady(forceReady), .runMode(runMode));
	ssq_sequencer #(.STEPS(8), .CONTACTS(5), .TENTH_CYCLES(4)) i_dut (
		.clk_sys(clk_sys), .srst(srst), .runMode(runMode), .autoMode(autoM), .powerUp(powerUp),
		.contactType(cType), .digitalInputContact(dic), .rampType(rampType), .rampSlopeUnitSetting(2'h0),
		.soakUnit(soakUnit), .pvStartMode(pvStart), .loopMode(loopMode), .stepCount(stepCount),
		.localSetpoint(local_setpoint), .stepRampRate(rate), .stepSoakTime(soakT), .processValue(pv),
		.processValueAlarm(pvAlarm), .rangeType(rangeType), .rangeLinear(rangeLinear), .rangeLow(rangeLow),
		.rangeHigh(rangeHigh), .limitWrite(limitWrite), .limitLowIn(limLo), .limitHighIn(limHi),
		.nvRunning(nvRunning), .nvStep(nvStep), .nvInSoak(nvInSoak), .nvStartSp(nvStartSp),
		.setpoint(setpoint), .stepIndex(stepIndex), .inRamp(inRamp), .inSoak(inSoak),
		.rampDisabled(rampDisabled), .forceReady(forceReady), .nvWrite(nvWrite), .nvWriteRunning(nvWRun),
		.nvWriteStep(), .nvWriteSoak(), .nvWriteStartSp(), .remainHi(remHi), .remainLo(remLo),
		.spLowLimit(spLo), .spHighLimit(spHi)
	);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic end_of_test();
		$display("checked %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : cyc

	// 0 soak, 1 ramp, 2 forced ready, 3+ step index; a hang shows as a mismatch
	task automatic waitc(input int sel);
		int n;
		n = 0;
		while (n < 3000 && !(sel == 0 ? inSoak === 1'b1 : sel == 1 ? inRamp === 1'b1
			: sel == 2 ? forceReady === 1'b1 : stepIndex === 3'(sel - 3))) begin
			@(negedge clk_sys);
			n++;
		end
		if (n == 3000) chk(16'h0, 16'h1);
	endtask : waitc

	task automatic go(input logic [1:0] t, input logic [1:0] l);
		rampType = t;
		loopMode = l;
		nvCnt = 0;
		runCmd = 1'b1;
	endtask : go

	task automatic halt();
		runCmd = 1'b0;
		pvAlarm = 1'b0;
		nvRunning = 1'b0;
		cyc(4);
	endtask : halt

	task automatic pwr(input logic [1:0] t, input logic s, input logic a);
		go(t, 2'h0);
		waitc(0);
		nvRunning = 1'b1;
		nvInSoak = s;
		pvAlarm = a;
		pv = 16'h0060;
		powerUp = 1'b1;
		cyc(1);
		powerUp = 1'b0;
		cyc(1);
	endtask : pwr

	function automatic logic [15:0] expRem(input logic [1:0] u, input logic [15:0] t);
		if (u == 2'h0) return (t > 16'h270f) ? 16'h6363 : {1'b0, 7'(t / 16'h64), 1'b0, 7'(t % 16'h64)};
		return (t > 16'h176f) ? 16'h6363 : {1'b0, 7'(t / 16'h3c), 1'b0, 7'(t % 16'h3c)};
	endfunction : expRem

	function automatic logic [15:0] expStart(input int m);
		if ((pvsT[m] == 2'h1 && pvT[m] < local_setpoint[0]) || (pvsT[m] == 2'h2 && pvT[m] > local_setpoint[0])) return pvT[m];
		return local_setpoint[0];
	endfunction : expStart

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{runCmd, powerUp, pvAlarm, rangeLinear, limitWrite, nvRunning, nvInSoak, dic} = '0;
		{rampType, soakUnit, pvStart, loopMode} = '0;
		autoM = 1'b1;
		stepCount = 4'h2;
		pv = 16'h0000;
		rangeType = 8'h02;
		rangeLow = 16'hff38;
		rangeHigh = 16'h04b0;
		limLo = 16'hffce;
		limHi = 16'h01f4;
		nvStep = 3'h1;
		nvStartSp = 16'h004d;
		for (int i = 0; i < 8; i++) begin
			local_setpoint[i] = 16'h0000;
			rate[i] = 16'h0005;
			soakT[i] = 16'h0003;
			if (i < 5) cType[i] = 5'h00;
		end
		local_setpoint[0] = 16'h0064;
		local_setpoint[1] = 16'h006e;
		soakT[1] = 16'h0002;
		cyc(8);
		srst = 1'b0;
		cyc(2);
		chk(spLo, rangeLow);
		limitWrite = 1'b1;
		cyc(1);
		limitWrite = 1'b0;
		rangeLinear = 1'b1;
		rangeType = 8'h58;
		cyc(2);
		chk(spLo, limLo);
		rangeLinear = 1'b0;
		rangeType = 8'h03;
		cyc(2);
		chk(spHi, rangeHigh);
		$display("done: limits");
		for (int k = 0; k < 20; k++) begin
			e = 1'b0;
			dic = 5'($random(seed));
			for (int i = 0; i < 5; i++) begin
				r = $random(seed);
				cType[i] = r[0] ? 5'h0d : {3'h0, r[2:1]};
				e = e | (dic[i] & r[0]);
			end
			cyc(1);
			chk({15'h0, rampDisabled}, {15'h0, e});
		end
		dic = 5'h00;
		$display("done: contacts");
		for (int k = 0; k < 5; k++) begin
			soakUnit = remU[k];
			soakT[0] = remT[k];
			cyc(2);
			chk({1'b0, remHi, 1'b0, remLo}, expRem(remU[k], remT[k]));
		end
		soakUnit = 2'h0;
		soakT[0] = 16'h0003;
		$display("done: remaining time");
		for (int m = 0; m < 5; m++) begin
			pvStart = pvsT[m];
			pv = pvT[m];
			go(2'h2, 2'h0);
			cyc(4);
			chk(setpoint, expStart(m));
			halt();
			chk({13'h0, stepIndex}, 16'h0);
		end
		pvStart = 2'h0;
		$display("done: pv start");
		go(2'h3, 2'h0);
		waitc(0);
		t0 = $time / 10;
		waitc(4);
		t0 = $time / 10 - t0;
		chk({15'h0, t0 >= 8 && t0 <= 14}, 16'h1);
		waitc(0);
		chk(setpoint, local_setpoint[1]);
		waitc(2);
		chk({15'h0, forceReady}, 16'h1);
		chk(16'(nvCnt), 16'h3);
		halt();
		go(2'h3, 2'h2);
		waitc(4);
		waitc(0);
		cyc(300);
		chk({12'h0, inSoak, stepIndex}, 16'h9);
		halt();
		go(2'h3, 2'h1);
		waitc(4);
		waitc(0);
		waitc(3);
		cyc(3);
		chk({15'h0, inRamp}, 16'h1);
		halt();
		$display("done: program ends");
		go(2'h3, 2'h0);
		waitc(4);
		waitc(1);
		cyc(45);
		cType[2] = 5'h0d;
		dic = 5'h04;
		cyc(2);
		sp = setpoint;
		chk({15'h0, inRamp}, 16'h0);
		cyc(3);
		chk(setpoint, sp);
		halt();
		dic = 5'h00;
		go(2'h0, 2'h0);
		cyc(4);
		rampType = 2'h3;
		waitc(2);
		cyc(2);
		chk({15'h0, runMode}, 16'h0);
		halt();
		$display("done: freeze and forced ready");
		pwr(2'h2, 1'b0, 1'b0);
		chk(setpoint, nvStartSp);
		cyc(1);
		chk({15'h0, runMode}, 16'h0);
		halt();
		pwr(2'h3, 1'b1, 1'b0);
		chk(setpoint, local_setpoint[1]);
		cyc(1);
		chk({12'h0, inSoak, stepIndex}, 16'h9);
		halt();
		pwr(2'h3, 1'b0, 1'b0);
		chk(setpoint, 16'h0060);
		cyc(1);
		chk({15'h0, inRamp}, 16'h1);
		pv = 16'h0050;
		autoM = 1'b0;
		cyc(1);
		autoM = 1'b1;
		cyc(1);
		chk(setpoint, 16'h0050);
		halt();
		pwr(2'h3, 1'b0, 1'b1);
		chk(setpoint, local_setpoint[1]);
		cyc(1);
		chk({15'h0, inSoak}, 16'h1);
		halt();
		$display("done: power return");
		end_of_test();
	end

	initial begin
		#300000;
		error_cnt++;
		end_of_test();
	end
endmodule : setpoint_step_program_sequencer_bench
